// ---- src/sgsw_top.sv ----
// Purpose: Automatic servo gain switching and ripple data warning.
// Assumes: APB master, one 40 MHz clock, condition inputs synchronous.
// Notes:   Ripple selection digits take effect on i_restart only.
`timescale 1ns/10ps
`include "sgsw_defines.svh"
//
// Overview of operation
// R1: Motor replaced with compensation on raises warning.
// R2: Reset value, disable, or mask clears warning.
// R3: Ripple digit 1 masks detection after restart.
// R4: Automatic switching happens only in position control.
// R5: Gain digit 0 value 2 enables, immediately.
// R6: Digit 0 value 1 is reserved, never written.
// R7: Set 1 and set 2 each hold five gains.
// R8: Model following gain and correction never switch.
// R9: A true goes to set 2, false back.
// R10: Digit 1 picks condition A, immediately.
// R11: Selections 4 and 5 watch the position reference.
// R12: Other control methods fix one set by selection.
// R13: Gains stay put until the waiting time ends.
// R14: Gains ramp linearly over the switching time.
// R15: Works for both PI and I-P speed loops.
// R16: Wait and ramp times are milliseconds, live.
// R17: Ripple digit 0 enables compensation after restart.
// R18: A reversal starts from the present gains.
// R19: Zero switching time applies target in one cycle.
module sgsw_top #(
   parameter int unsigned P_CYC_PER_MS = `SGSW_CYC_PER_MS // Cycles/ms.
) (
   input  wire logic                   i_mclk,          // 40 MHz clock.
   input  wire logic                   i_rst,           // Sync reset.
   input  wire sgsw_pkg::sgsw_apb_req_t i_apb,          // APB request.
   output sgsw_pkg::sgsw_apb_rsp_t      o_apb,          // APB answer.
   input  wire sgsw_pkg::sgsw_mode_t    i_ctrl_mode,    // Control method.
   input  wire sgsw_pkg::sgsw_cond_t    i_cond,         // Condition A.
   input  wire logic                   i_ip_control,   // Speed loop I-P.
   input  wire logic                   i_restart,      // Soft restart.
   input  wire logic                   i_motor_replaced, // Pulse.
   output sgsw_pkg::sgsw_gains_t        o_gains,        // Applied gains.
   output logic [15:0]                 o_mf_gain,      // Not switched.
   output logic [15:0]                 o_mf_corr,      // Not switched.
   output logic                        o_gain_set2,    // Set 2 chosen.
   output logic                        o_switching,    // Wait or ramp.
   output logic                        o_ripple_comp_en, // Comp active.
   output logic                        o_ripple_warn   // Data mismatch.
);
   import sgsw_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Register storage and APB slave.

   logic [15:0] regs_r [`SGSW_NSLOT];  // Parameter words.
   logic        pready_r;              // Answer in the access cycle.
   logic        pslverr_r;
   logic [31:0] prdata_r;
   logic [13:0] idx;                   // Word index of the access.
   logic [5:0]  hit_slot;              // Hit flag and slot.
   logic [4:0]  slot;
   logic        hit;
   logic        bad;                   // Unmapped, misaligned, or status write.
   logic [15:0] rd_word;
   logic [15:0] stat_word;
   logic        setup;
   logic        wr_commit;
   logic        cmd_rcrst;             // Reset compensation value.

   // Address decode shared by read and write paths.
   function automatic logic [5:0] slot_of(input logic [13:0] ix);
      logic [5:0] r;
      r = 6'h00;
      if      (ix == `SGSW_IDX_GSEL)  r = {1'b1, `SGSW_SL_GSEL};
      else if (ix == `SGSW_IDX_RSEL)  r = {1'b1, `SGSW_SL_RSEL};
      else if (ix == `SGSW_IDX_SPD1)  r = {1'b1, `SGSW_SL_SET1};
      else if (ix == `SGSW_IDX_INT1)  r = {1'b1, 5'(`SGSW_SL_SET1 + 1)};
      else if (ix == `SGSW_IDX_POS1)  r = {1'b1, 5'(`SGSW_SL_SET1 + 2)};
      else if (ix == `SGSW_IDX_TRQ1)  r = {1'b1, 5'(`SGSW_SL_SET1 + 3)};
      else if (ix == `SGSW_IDX_FRC1)  r = {1'b1, 5'(`SGSW_SL_SET1 + 4)};
      else if (ix == `SGSW_IDX_SPD2)  r = {1'b1, `SGSW_SL_SET2};
      else if (ix == `SGSW_IDX_INT2)  r = {1'b1, 5'(`SGSW_SL_SET2 + 1)};
      else if (ix == `SGSW_IDX_POS2)  r = {1'b1, 5'(`SGSW_SL_SET2 + 2)};
      else if (ix == `SGSW_IDX_TRQ2)  r = {1'b1, 5'(`SGSW_SL_SET2 + 3)};
      else if (ix == `SGSW_IDX_FRC2)  r = {1'b1, 5'(`SGSW_SL_SET2 + 4)};
      else if (ix == `SGSW_IDX_RAMP1) r = {1'b1, `SGSW_SL_RAMP1};
      else if (ix == `SGSW_IDX_RAMP2) r = {1'b1, `SGSW_SL_RAMP2};
      else if (ix == `SGSW_IDX_WAIT1) r = {1'b1, `SGSW_SL_WAIT1};
      else if (ix == `SGSW_IDX_WAIT2) r = {1'b1, `SGSW_SL_WAIT2};
      else if (ix == `SGSW_IDX_MFG)   r = {1'b1, `SGSW_SL_MFG};
      else if (ix == `SGSW_IDX_MFC)   r = {1'b1, `SGSW_SL_MFC};
      else if (ix == `SGSW_IDX_STAT)  r = {1'b1, `SGSW_SL_STAT};
      else if (ix == `SGSW_IDX_CMD)   r = {1'b1, `SGSW_SL_CMD};
      return r;
   endfunction

   // Reset value of each stored word.
   function automatic logic [15:0] rst_val(input int s);
      logic [15:0] v;
      v = `SGSW_RST_ZERO;
      if (s == `SGSW_SL_SET1 || s == `SGSW_SL_SET2)         v = `SGSW_RST_SPD;
      else if (s == `SGSW_SL_SET1+1 || s == `SGSW_SL_SET2+1) v = `SGSW_RST_INT;
      else if (s == `SGSW_SL_SET1+2 || s == `SGSW_SL_SET2+2) v = `SGSW_RST_POS;
      else if (s == `SGSW_SL_SET1+3 || s == `SGSW_SL_SET2+3) v = `SGSW_RST_TRQ;
      else if (s == `SGSW_SL_SET1+4 || s == `SGSW_SL_SET2+4) v = `SGSW_RST_FRC;
      else if (s == `SGSW_SL_MFG || s == `SGSW_SL_MFC)       v = `SGSW_RST_MF;
      return v;
   endfunction

   assign idx      = i_apb.paddr[15:2];
   assign hit_slot = slot_of(idx);
   assign hit      = hit_slot[5];
   assign slot     = hit_slot[4:0];
   // Status is read only; writing it is answered with an error.
   assign bad      = !hit || (i_apb.paddr[1:0] != 2'b00) ||
                     (i_apb.pwrite && slot == `SGSW_SL_STAT);
   assign rd_word  = (slot == `SGSW_SL_STAT) ? stat_word :
                     (slot == `SGSW_SL_CMD)  ? `SGSW_RST_ZERO :
                     regs_r[slot];
   assign setup    = i_apb.psel && !i_apb.penable;
   // Writes land only at the edge that completes the access.
   assign wr_commit = i_apb.psel && i_apb.penable && pready_r &&
                      i_apb.pwrite && !pslverr_r;
   assign cmd_rcrst = wr_commit && slot == `SGSW_SL_CMD &&
                      i_apb.pwdata[`SGSW_CMD_RCRST];

   // APB answer registers.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup && bad;
         prdata_r  <= setup ? {16'h0000, rd_word} : prdata_r;
      end
   end

   // Parameter storage; times and gains are live at once.
   always_ff @(posedge i_mclk) begin
      for (int s = 0; s < `SGSW_NSLOT; s++) begin
         if (i_rst)
            regs_r[s] <= rst_val(s);
         else if (wr_commit && slot == 5'(s))
            regs_r[s] <= i_apb.pwdata[15:0]; // R16
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Ripple compensation warning.

   logic rc_en_r;     // Compensation enable seen at restart.
   logic nodet_r;     // Detection mask seen at restart.
   logic warn_r;
   logic warn_set;
   logic warn_clr;

   assign warn_set = i_motor_replaced && rc_en_r && !nodet_r; // R1
   assign warn_clr = cmd_rcrst || !rc_en_r || nodet_r;        // R2
   // An event in the clearing cycle still sets the flag.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rc_en_r <= 1'b0;
         nodet_r <= 1'b0;
         warn_r  <= 1'b0;
      end else begin
         if (i_restart) begin
            rc_en_r <= regs_r[`SGSW_SL_RSEL][`SGSW_DIG0] ==
                       `SGSW_RC_EN;                            // R17
            nodet_r <= regs_r[`SGSW_SL_RSEL][`SGSW_DIG1] ==
                       `SGSW_RC_NODET;                         // R3
         end
         warn_r <= warn_set || (warn_r && !warn_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Gain switching control.

   sgsw_state_t st_r;
   sgsw_state_t st_nxt;
   logic        goal_r;         // Set 2 is the goal.
   logic        goal_nxt;
   logic        sw_r;           // Wait or ramp under way, registered.
   logic        desired;
   logic        cond_a;
   logic        auto_en;
   logic        load;
   logic        cnt_clr;
   logic [15:0] cyc_r;          // Cycles within the millisecond.
   logic [15:0] ms_r;           // Milliseconds in this state.
   logic        tick;
   logic [15:0] wait_sel;
   logic [15:0] ramp_sel;
   logic [3:0]  ca_sel;
   logic [15:0] elapsed;

   // Condition A from its selection; unknown codes count as false.
   function automatic logic eval_a(input logic [3:0] sel,
                                   input sgsw_cond_t c);
      logic r;
      r = 1'b0;
      if      (sel == `SGSW_CA_DONE_ON)  r = c.pos_done;   // R10
      else if (sel == `SGSW_CA_DONE_OFF) r = !c.pos_done;
      else if (sel == `SGSW_CA_NEAR_ON)  r = c.near;
      else if (sel == `SGSW_CA_NEAR_OFF) r = !c.near;
      else if (sel == `SGSW_CA_REF_IDLE) r = c.ref_filt_zero &&
                                             !c.ref_in;    // R11
      else if (sel == `SGSW_CA_REF_IN)   r = c.ref_in;
      return r;
   endfunction

   assign ca_sel  = regs_r[`SGSW_SL_GSEL][`SGSW_DIG1];
   assign cond_a  = eval_a(ca_sel, i_cond);
   // Reserved value 1 leaves the function off, like value 0.
   assign auto_en = regs_r[`SGSW_SL_GSEL][`SGSW_DIG0] == `SGSW_AUTO_ON &&
                    i_ctrl_mode == SGSW_POS;                  // R4 R5 R6
   // Outside position control, odd selections fix set 2, even ones set 1.
   assign desired = auto_en ? cond_a :
                    (i_ctrl_mode != SGSW_POS && ca_sel[0]);   // R12 R9
   assign wait_sel = goal_r ? regs_r[`SGSW_SL_WAIT1] :
                              regs_r[`SGSW_SL_WAIT2];         // R9
   assign ramp_sel = goal_r ? regs_r[`SGSW_SL_RAMP1] :
                              regs_r[`SGSW_SL_RAMP2];
   assign tick    = cyc_r == 16'(P_CYC_PER_MS - 1);
   assign elapsed = (ms_r > ramp_sel) ? ramp_sel : ms_r;

   // Next state: under automatic switching a change of goal restarts the wait from present gains.
   always_comb begin
      st_nxt   = st_r;
      goal_nxt = goal_r;
      load     = 1'b0;
      cnt_clr  = 1'b0;
      if (desired != goal_r) begin
         goal_nxt = desired;
         cnt_clr  = 1'b1;
         if (auto_en) begin
            st_nxt = ST_WAIT;                                 // R18
            load   = 1'b1;
         end else begin
            st_nxt = ST_IDLE;
         end
      end else if (!auto_en) begin
         st_nxt = ST_IDLE;
      end else begin
         case (st_r)
            ST_WAIT: begin
               if (ms_r >= wait_sel) begin                    // R13
                  cnt_clr = 1'b1;
                  st_nxt  = (ramp_sel == 16'h0000) ? ST_IDLE : ST_RAMP;
               end                                            // R19
            end
            ST_RAMP: begin
               if (ms_r >= ramp_sel)
                  st_nxt = ST_IDLE;
            end
            default: begin
               st_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // Switcher state and millisecond timer.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_r   <= ST_IDLE;
         sw_r   <= 1'b0;
         goal_r <= 1'b0;
         cyc_r  <= 16'h0000;
         ms_r   <= 16'h0000;
      end else begin
         st_r   <= st_nxt;
         sw_r   <= st_nxt != ST_IDLE;
         goal_r <= goal_nxt;
         cyc_r  <= (cnt_clr || tick) ? 16'h0000 : 16'(cyc_r + 1'b1);
         if (cnt_clr)
            ms_r <= 16'h0000;
         else if (tick && ms_r != 16'hFFFF)
            ms_r <= 16'(ms_r + 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Five switched gains; the same path serves PI and I-P loops.

   logic [4:0][15:0] gain_vec;

   for (genvar g = 0; g < `SGSW_NGAIN; g++) begin : g_gain
      sgsw_ramp u_ramp (
         .i_mclk    (i_mclk),
         .i_rst     (i_rst),
         .i_load    (load),
         .i_hold    (st_r == ST_WAIT),
         .i_ramp    (st_r == ST_RAMP),
         .i_elapsed (elapsed),
         .i_total   (ramp_sel),
         .i_target  (goal_r ? regs_r[`SGSW_SL_SET2 + g] :
                              regs_r[`SGSW_SL_SET1 + g]), // R7 R15
         .i_init    (regs_r[`SGSW_SL_SET1 + g]),
         .o_value   (gain_vec[g])
      );
   end

   assign stat_word = {10'h000, i_ip_control, rc_en_r, nodet_r, warn_r,
                       st_r != ST_IDLE, goal_r};

   assign o_apb            = '{pready: pready_r, pslverr: pslverr_r,
                               prdata: prdata_r};
   assign o_gains          = sgsw_gains_t'(gain_vec);
   assign o_mf_gain        = regs_r[`SGSW_SL_MFG];            // R8
   assign o_mf_corr        = regs_r[`SGSW_SL_MFC];
   assign o_gain_set2      = goal_r;
   assign o_switching      = sw_r;
   assign o_ripple_comp_en = rc_en_r;
   assign o_ripple_warn    = warn_r;

   ////////////////////////////////////////////////////////////////////
   // Checks.

   a_warn_raise: assert property (@(posedge i_mclk) disable iff (i_rst)
      warn_set |=> warn_r) else $error("warning not raised"); // R1
   a_warn_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
      (!rc_en_r || nodet_r) && !warn_set |=> !warn_r)
      else $error("warning not cleared"); // R2
   a_mask_restart: assert property (@(posedge i_mclk) disable iff (i_rst)
      !i_restart |=> $stable(nodet_r) && $stable(rc_en_r))
      else $error("ripple setting changed without restart"); // R3
   a_auto_posonly: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_ctrl_mode != SGSW_POS |=> st_r == ST_IDLE)
      else $error("switching outside position control"); // R4
   a_auto_enable: assert property (@(posedge i_mclk) disable iff (i_rst)
      regs_r[`SGSW_SL_GSEL][`SGSW_DIG0] != `SGSW_AUTO_ON
      |=> !o_switching) else $error("switching while disabled"); // R5
   a_fixed_set: assert property (@(posedge i_mclk) disable iff (i_rst)
      i_ctrl_mode != SGSW_POS |=> o_gain_set2 == $past(ca_sel[0]))
      else $error("wrong fixed set"); // R12
   a_wait_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
      st_r == ST_WAIT && $past(st_r) == ST_WAIT |-> $stable(gain_vec))
      else $error("gain moved during wait"); // R13
   // Speed gain target, so the zero-time check can see what is due.
   logic [15:0] spd_tgt;
   assign spd_tgt = goal_r ? regs_r[`SGSW_SL_SET2] : regs_r[`SGSW_SL_SET1];
   a_zero_ramp: assert property (@(posedge i_mclk) disable iff (i_rst)
      st_r == ST_WAIT && auto_en && desired == goal_r && ramp_sel == 16'h0000
      && ms_r >= wait_sel |=> ##1 $past(load) || gain_vec[0] == $past(spd_tgt))
      else $error("zero ramp not applied"); // R19
   a_mf_fixed: assert property (@(posedge i_mclk) disable iff (i_rst)
      $changed(goal_r) |-> $stable(o_mf_gain) || $past(wr_commit))
      else $error("model gain switched"); // R8

endmodule // sgsw_top

// ---- src/sgsw_defines.svh ----
// Purpose: Named constants for the servo gain switch and ripple warning.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Register indices are word indices; byte address is index * 4.
`ifndef SGSW_DEFINES_SVH
`define SGSW_DEFINES_SVH

// Data width of every parameter word.
`define SGSW_DW          16
// Register indices (byte address = index * 4).
`define SGSW_IDX_GSEL    14'h2139
`define SGSW_IDX_RSEL    14'h2423
`define SGSW_IDX_SPD1    14'h2100
`define SGSW_IDX_INT1    14'h2101
`define SGSW_IDX_POS1    14'h2102
`define SGSW_IDX_TRQ1    14'h2401
`define SGSW_IDX_FRC1    14'h2121
`define SGSW_IDX_SPD2    14'h2104
`define SGSW_IDX_INT2    14'h2105
`define SGSW_IDX_POS2    14'h2106
`define SGSW_IDX_TRQ2    14'h2412
`define SGSW_IDX_FRC2    14'h2122
`define SGSW_IDX_RAMP1   14'h2131
`define SGSW_IDX_RAMP2   14'h2132
`define SGSW_IDX_WAIT1   14'h2135
`define SGSW_IDX_WAIT2   14'h2136
`define SGSW_IDX_MFG     14'h2141
`define SGSW_IDX_MFC     14'h2142
`define SGSW_IDX_STAT    14'h2A00
`define SGSW_IDX_CMD     14'h2A01
// Storage slots inside the register array; status and command slots lie past its end.
`define SGSW_SL_GSEL     5'h00
`define SGSW_SL_RSEL     5'h01
`define SGSW_SL_SET1     5'h02
`define SGSW_SL_SET2     5'h07
`define SGSW_SL_RAMP1    5'h0C
`define SGSW_SL_RAMP2    5'h0D
`define SGSW_SL_WAIT1    5'h0E
`define SGSW_SL_WAIT2    5'h0F
`define SGSW_SL_MFG      5'h10
`define SGSW_SL_MFC      5'h11
`define SGSW_SL_STAT     5'h12
`define SGSW_SL_CMD      5'h13
`define SGSW_NSLOT       18
`define SGSW_NGAIN       5
// Digit fields of the selection words.
`define SGSW_DIG0        3:0
`define SGSW_DIG1        7:4
`define SGSW_AUTO_ON     4'h2
`define SGSW_CA_DONE_ON  4'h0
`define SGSW_CA_DONE_OFF 4'h1
`define SGSW_CA_NEAR_ON  4'h2
`define SGSW_CA_NEAR_OFF 4'h3
`define SGSW_CA_REF_IDLE 4'h4
`define SGSW_CA_REF_IN   4'h5
`define SGSW_RC_EN       4'h1
`define SGSW_RC_NODET    4'h1
`define SGSW_CMD_RCRST   0
// Reset values of the parameter words.
`define SGSW_RST_ZERO    16'h0000
`define SGSW_RST_SPD     16'h0190
`define SGSW_RST_INT     16'h07D0
`define SGSW_RST_POS     16'h0190
`define SGSW_RST_TRQ     16'h0064
`define SGSW_RST_FRC     16'h0064
`define SGSW_RST_MF      16'h0000
// Timing: one millisecond at a 25 ns clock.
`define SGSW_MS_NS       1000000
`define SGSW_CLK_NS      25
`define SGSW_CYC_PER_MS  (`SGSW_MS_NS / `SGSW_CLK_NS)

`endif

// ---- src/sgsw_pkg.sv ----
// Purpose: Types shared by the servo gain switch design files.
// Assumes: Constants come from sgsw_defines.svh.
// Notes:   Packed structs carry grouped signals across ports.
package sgsw_pkg;

   // Control method of the drive.
   typedef enum logic [1:0] {
      SGSW_POS,
      SGSW_SPD,
      SGSW_TRQ
   } sgsw_mode_t;

   // Transition state of the gain switcher.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_RAMP
   } sgsw_state_t;

   // One set of switched gains.
   typedef struct packed {
      logic [15:0] fric;
      logic [15:0] trq_filt;
      logic [15:0] pos_gain;
      logic [15:0] spd_int;
      logic [15:0] spd_gain;
   } sgsw_gains_t;

   // Inputs that condition A can look at.
   typedef struct packed {
      logic pos_done;
      logic near;
      logic ref_filt_zero;
      logic ref_in;
   } sgsw_cond_t;

   // APB request from the master.
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } sgsw_apb_req_t;

   // APB answer to the master.
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sgsw_apb_rsp_t;

endpackage

// ---- src/sgsw_ramp.sv ----
// Purpose: One switched gain: hold, linear ramp, or follow its target.
// Assumes: Controls come from the switcher in sgsw_top; i_load is combinational.
// Notes:   The divide is wide but runs once per clock, not per step.
`timescale 1ns/10ps
`include "sgsw_defines.svh"
module sgsw_ramp (
   input  wire logic              i_mclk,    // Control clock.
   input  wire logic              i_rst,     // Synchronous reset.
   input  wire logic              i_load,    // Capture start value.
   input  wire logic              i_hold,    // Freeze during wait.
   input  wire logic              i_ramp,    // Interpolate.
   input  wire logic [15:0]       i_elapsed, // Ramp time spent, ms.
   input  wire logic [15:0]       i_total,   // Ramp time, ms.
   input  wire logic [15:0]       i_target,  // Value of the new set.
   input  wire logic [15:0]       i_init,    // Unused; reset loads zero.
   output logic      [15:0]       o_value    // Applied gain.
);

   logic        [15:0] from_r;    // Start value of the transition.
   logic        [15:0] from_nxt;
   logic        [15:0] value_r;   // Applied value.
   logic        [15:0] value_nxt;
   logic signed [16:0] diff;      // Signed span of the ramp.
   logic signed [33:0] prod;      // Span times elapsed time.
   logic signed [33:0] quot;      // Share of the span reached.
   logic        [15:0] interp;    // Interpolated value.

   // Linear point between start and target; total of zero is never
   // ramped, the switcher goes straight to follow mode instead.
   assign diff   = $signed({1'b0, i_target}) - $signed({1'b0, from_r});
   assign prod   = diff * $signed({1'b0, i_elapsed});
   assign quot   = (i_total == 16'h0000) ? prod :
                   prod / $signed({18'h00000, i_total});
   assign interp = 16'(from_r + quot[15:0]);

   // A reversal keeps the present value so that no step appears.
   assign from_nxt  = i_load ? value_r : from_r;
   assign value_nxt = (i_load | i_hold) ? value_r :
                      (i_ramp ? interp : i_target); // R14

   ////////////////////////////////////////////////////////////////////
   // State registers.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         from_r  <= `SGSW_RST_ZERO;
         value_r <= `SGSW_RST_ZERO;
      end else begin
         from_r  <= from_nxt;
         value_r <= value_nxt;
      end
   end

   assign o_value = value_r;

   // Unused; reset loads zero and the first follow cycle loads the target.
   logic unused_init;
   assign unused_init = ^i_init;

endmodule // sgsw_ramp

// ---- dv/sgsw_loop_model.sv ----
// Purpose: Model of the servo loops that report axis settling.
// Assumes: One clock; the bench says when the axis is at target.
// Notes:   Flags lag the request by one cycle, as real loops do.
`timescale 1ns/10ps
module sgsw_loop_model (
   input  wire logic            i_mclk,   // Control clock.
   input  wire logic            i_settle, // Axis at target.
   output sgsw_pkg::sgsw_cond_t o_cond    // Loop status flags.
);
   import sgsw_pkg::*;
   initial o_cond = '0;
   // A settled axis is done, near, and sees no reference input.
   always @(posedge i_mclk) begin
      o_cond <= '{i_settle, i_settle, i_settle, !i_settle};
   end
endmodule // sgsw_loop_model

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the gain switch and ripple warning.
// Assumes: Four cycles per millisecond to keep the run short.
// Notes:   Bus reads are noted in a queue and checked by a monitor.
`timescale 1ns/10ps
`include "sgsw_defines.svh"
module testbench;
   import sgsw_pkg::*;
   logic          clk = 0, rst = 1, settle = 0, ip = 0, rs = 0, mrep = 0;
   sgsw_apb_req_t req = '0;   // Bus request.
   sgsw_apb_rsp_t rsp;        // Bus answer.
   sgsw_mode_t    mode = SGSW_POS;
   sgsw_cond_t    cond;
   sgsw_gains_t   g;
   logic [15:0]   mfg, mfc;
   logic          set2, sw, cen, warn;
   logic [17:0]   note_q[$];  // Expected {read, error, data}.
   int            bad_count = 0, tests_run = 0;
   always #12.5 clk = ~clk;
   sgsw_top #(.P_CYC_PER_MS(4)) u_dut (.i_mclk(clk), .i_rst(rst),
      .i_apb(req), .o_apb(rsp), .i_ctrl_mode(mode), .i_cond(cond),
      .i_ip_control(ip), .i_restart(rs), .i_motor_replaced(mrep),
      .o_gains(g), .o_mf_gain(mfg), .o_mf_corr(mfc), .o_gain_set2(set2),
      .o_switching(sw), .o_ripple_comp_en(cen), .o_ripple_warn(warn));
   sgsw_loop_model u_loop (.i_mclk(clk), .i_settle(settle), .o_cond(cond));
   ////////////////////////////////////////////////////////////////////
   task check(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done;
      if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One bus transfer; the answer is awaited under a bound.
   task apb(input logic w, input logic [13:0] ix, input logic [15:0] d,
            input logic e, input logic [15:0] x);
      int k;
      note_q.push_back({!w, e, x});
      @(posedge clk) req <= '{1'b1, 1'b0, w, {ix, 2'b00}, {16'h0000, d}};
      @(posedge clk) req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 20);
      if (rsp.pready !== 1'b1) begin
         bad_count++;
         test_done;
      end
      req <= '0;
   endtask
   // Pulse restart or motor replacement, then let the flags settle.
   task pulse(input logic restart);
      if (restart) rs <= 1'b1;
      else mrep <= 1'b1;
      tick(1);
      rs <= 1'b0;
      mrep <= 1'b0;
      tick(2);
   endtask
   // Monitor: each completed transfer is matched to its oldest note.
   always @(posedge clk) begin
      if (req.psel && req.penable && rsp.pready === 1'b1) begin
         check("pslverr", 16'(rsp.pslverr), 16'(note_q[0][16]));
         if (note_q[0][17])
            check("prdata", rsp.prdata[15:0], note_q[0][15:0]);
         void'(note_q.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      int s, k;
      logic ex;
      logic [15:0] r;
      void'($urandom(32'hC17F));
      tick(4);
      rst <= 1'b0;
      r = 16'h1000 + 16'($urandom_range(0, 16'h6FFF));
      apb(0, `SGSW_IDX_GSEL, 0, 0, 16'h0000);
      apb(0, `SGSW_IDX_RSEL, 0, 0, 16'h0000);
      apb(0, 14'h2000, 0, 1, 16'h0000);
      apb(1, `SGSW_IDX_STAT, 1, 1, 16'h0000);
      apb(1, `SGSW_IDX_SPD2, r, 0, 16'h0000);
      apb(1, `SGSW_IDX_FRC2, r, 0, 16'h0000);
      apb(1, `SGSW_IDX_TRQ2, r, 0, 16'h0000);
      // Every condition code in position control, then codes 0 to 2 in speed and 3 to 5 in torque control.
      for (s = 0; s < 12; s++) begin
         mode <= (s < 6) ? SGSW_POS : (s < 9) ? SGSW_SPD : SGSW_TRQ;
         settle <= 1'b1;
         apb(1, `SGSW_IDX_GSEL, {8'h00, 4'(s % 6), 4'h2}, 0, 16'h0000);
         tick(6);
         ex = ((s % 2) == 0) == (s < 6);
         check("gain_set2", 16'(set2), 16'(ex));
         check("spd_gain", g.spd_gain, ex ? r : `SGSW_RST_SPD);
         check("fric", g.fric, ex ? r : `SGSW_RST_FRC);
         check("trq_filt", g.trq_filt, ex ? r : `SGSW_RST_TRQ);
         check("pos_gain", g.pos_gain, `SGSW_RST_POS);
         check("spd_int", g.spd_int, `SGSW_RST_INT);
         check("mf_gain", mfg, `SGSW_RST_MF);
      end
      // Timed switch: one millisecond wait, two millisecond ramp.
      mode <= SGSW_POS;
      settle <= 1'b0;
      apb(1, `SGSW_IDX_GSEL, 16'h0002, 0, 16'h0000);
      apb(1, `SGSW_IDX_WAIT1, 1, 0, 16'h0000);
      apb(1, `SGSW_IDX_RAMP1, 2, 0, 16'h0000);
      tick(4);
      settle <= 1'b1;
      tick(3);
      check("switching", 16'(sw), 16'h0001);
      check("wait_hold", g.spd_gain, `SGSW_RST_SPD);
      for (k = 0; k < 200 && sw !== 1'b0; k++) tick(1);
      if (sw !== 1'b0) begin
         bad_count++;
         test_done;
      end
      check("ramp_end", g.spd_gain, r);
      check("mf_corr", mfc, `SGSW_RST_MF);
      settle <= 1'b0;
      tick(6);
      check("zero_time", g.spd_gain, `SGSW_RST_SPD);
      // Ripple data warning: enable, detect, clear, mask.
      apb(1, `SGSW_IDX_RSEL, 16'h0001, 0, 16'h0000);
      pulse(0);
      check("warn_pre", 16'(warn), 16'h0000);
      pulse(1);
      check("comp_en", 16'(cen), 16'h0001);
      pulse(0);
      check("warn_set", 16'(warn), 16'h0001);
      apb(1, `SGSW_IDX_CMD, 16'h0001, 0, 16'h0000);
      tick(2);
      check("warn_cmd", 16'(warn), 16'h0000);
      pulse(0);
      check("warn_again", 16'(warn), 16'h0001);
      apb(1, `SGSW_IDX_RSEL, 16'h0011, 0, 16'h0000);
      pulse(1);
      check("warn_mask", 16'(warn), 16'h0000);
      pulse(0);
      check("warn_nodet", 16'(warn), 16'h0000);
      apb(0, `SGSW_IDX_RSEL, 0, 0, 16'h0011);
      ip <= 1'b1;
      apb(0, `SGSW_IDX_STAT, 0, 0, 16'h0038);
      test_done;
   end
endmodule // testbench
